// ==== buck_cfg_pkg.sv ====
// Purpose: shared constants and types for the buck set-point and dead-time block
// Assumes: 40 MHz system clock, 32-bit AHB-Lite register bus
// Notes: every register sits in the low byte of one aligned word
package buck_cfg_pkg;

	// =========================================================
	// register map (byte addresses)
	localparam logic [7:0] DEAD_TIME_OFFSET = 8'h00;
	localparam logic [7:0] COARSE_OFFSET = 8'h04;
	localparam logic [7:0] FINE_OFFSET = 8'h08;
	localparam logic [7:0] UV_LEVEL_OFFSET = 8'h0c;
	localparam logic [7:0] PERIPH_EN_OFFSET = 8'h10;
	localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h14;
	localparam logic [7:0] IRQ_MASK_OFFSET = 8'h18;
	localparam int ADDR_DECODE_BITS = 8;

	// =========================================================
	// reset values
	localparam logic [7:0] DEAD_TIME_RESET = 8'h00;
	localparam logic [7:0] COARSE_RESET = 8'h00;
	localparam logic [7:0] FINE_RESET = 8'h00;
	localparam logic [7:0] UV_LEVEL_RESET = 8'h00;
	localparam logic [7:0] PERIPH_EN_RESET = 8'h00;

	// =========================================================
	// field positions
	localparam int FINE_ENABLE_BIT = 7;
	localparam logic [7:0] FINE_WRITE_MASK = 8'h9f;
	localparam int HIGH_BYPASS_BIT = 5;
	localparam int LOW_BYPASS_BIT = 4;
	localparam int UV_FAST_OFF_BIT = 1;
	localparam logic [7:0] PERIPH_WRITE_MASK = 8'h32;
	localparam int UV_EVENT_BIT = 0;

	// =========================================================
	// dead-time timing: delay = base + code * step, in ns
	localparam int CLK_PERIOD_NS = 25;
	localparam int HIGH_BASE_NS = 11;
	localparam int LOW_BASE_NS = 4;
	localparam int DELAY_STEP_NS = 4;

	// =========================================================
	// AHB-Lite encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;

	typedef struct packed {
		logic [3:0] high_side_delay_code;
		logic [3:0] low_side_delay_code;
	} dead_time_control_t;

	typedef struct packed {
		logic reference_converter_enable;
		logic [1:0] unused;
		logic [4:0] fine_setpoint_code;
	} fine_setpoint_t;

	typedef struct packed {
		logic enable;
		logic [7:0] coarse_setpoint_code;
		logic [4:0] fine_setpoint_code;
	} reference_out_t;

	typedef enum logic [1:0] {
		GATE_OFF = 2'h0,
		GATE_WAIT = 2'h1,
		GATE_ON = 2'h3
	} gate_state_t;

endpackage

// ==== buck_cfg_props.sv ====
// Purpose: concurrent checks on the set-point and dead-time register block
// Assumes: one clock, zero-wait bus, reference outputs one edge behind registers
// Notes: sees only the top ports; data-phase decode is rebuilt locally
`timescale 1ns/10ps
module buck_cfg_props
	import buck_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	input wire logic high_side_request,
	input wire logic low_side_request,
	input wire logic undervoltage_compare_raw,
	input wire logic high_side_gate_signal,
	input wire logic low_side_gate_signal,
	input wire logic reference_converter_enable,
	input wire logic [7:0] coarse_setpoint_code,
	input wire logic [4:0] fine_setpoint_code,
	input wire logic [7:0] undervoltage_level_code,
	input wire logic irq
);
	// =========================================================
	// data-phase tracking
	logic dp_q;
	logic dp_wr_q;
	logic [7:0] dp_a_q;
	logic dp_w;
	// address captured only when the bus is ready, as the slave does
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_q <= 1'b0;
			dp_wr_q <= 1'b0;
			dp_a_q <= 8'h00;
		end else if (hready) begin
			dp_q <= hsel && htrans[1];
			dp_wr_q <= hwrite;
			dp_a_q <= haddr[7:0];
		end
	end
	assign dp_w = dp_q && dp_wr_q;

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// =========================================================
	// properties
	property p_fine_zero;
		dp_q && !dp_wr_q && dp_a_q == FINE_OFFSET |-> hrdata[6:5] == 2'h0;
	endproperty
	a_fine_zero: assert property (p_fine_zero) else $error("fine unused bits read nonzero");
	property p_ref_off;
		!reference_converter_enable |-> coarse_setpoint_code == 8'h00 && fine_setpoint_code == 5'h00;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("codes live while converter off");
	property p_ref_en;
		dp_w && dp_a_q == FINE_OFFSET |-> ##2 reference_converter_enable == $past(hwdata[7], 2);
	endproperty
	a_ref_en: assert property (p_ref_en) else $error("enable not following fine write");
	property p_coarse;
		dp_w && dp_a_q == COARSE_OFFSET |->
			##2 coarse_setpoint_code == ($past(hwdata[7:0], 2) & {8{reference_converter_enable}});
	endproperty
	a_coarse: assert property (p_coarse) else $error("coarse code not following write");
	property p_uv_lvl;
		dp_w && dp_a_q == UV_LEVEL_OFFSET |-> ##2 undervoltage_level_code == $past(hwdata[7:0], 2);
	endproperty
	a_uv_lvl: assert property (p_uv_lvl) else $error("threshold code not following write");
	// irq may only drop after a register write cleared or masked it
	property p_irq_hold;
		$fell(irq) |-> $past(dp_w) || $past(dp_w, 2);
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without a write");
	// eight cycles covers sync, release of the kill and the longest delay
	property p_hs_on;
		(high_side_request && !undervoltage_compare_raw) [*8] |-> high_side_gate_signal;
	endproperty
	a_hs_on: assert property (p_hs_on) else $error("high gate late");
	property p_ls_on;
		(low_side_request && !undervoltage_compare_raw) [*8] |-> low_side_gate_signal;
	endproperty
	a_ls_on: assert property (p_ls_on) else $error("low gate late");
	property p_hs_off;
		$fell(high_side_request) ##1 !high_side_request |-> ##1 !high_side_gate_signal;
	endproperty
	a_hs_off: assert property (p_hs_off) else $error("high gate off edge delayed");

	c_irq: cover property ($rose(irq));
	c_fine: cover property (dp_q && !dp_wr_q && dp_a_q == FINE_OFFSET);
	c_gate: cover property ($rose(high_side_gate_signal));
endmodule

// ==== buck_driver_setpoint_config.sv ====
// Purpose: register bank for driver dead time, output reference and undervoltage detect
// Assumes: single 40 MHz clock, AHB-Lite slave with zero wait states
// Notes: analog converter and comparator sit outside; this block drives their codes
`timescale 1ns/10ps
module buck_driver_setpoint_config
	import buck_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic high_side_request,
	input wire logic low_side_request,
	input wire logic undervoltage_compare_raw,
	output logic high_side_gate_signal,
	output logic low_side_gate_signal,
	output logic reference_converter_enable,
	output logic [7:0] coarse_setpoint_code,
	output logic [4:0] fine_setpoint_code,
	output logic [7:0] undervoltage_level_code,
	output logic irq
);

	// =========================================================
	// register storage
	dead_time_control_t dead_time_q;
	logic [7:0] coarse_setpoint_q;
	fine_setpoint_t fine_setpoint_q;
	logic [7:0] undervoltage_level_q;
	logic [7:0] analog_peripheral_enables_q;
	logic [7:0] irq_status_q;
	logic [7:0] irq_mask_q;

	// bus pipeline
	logic wr_pending_q;
	logic [ADDR_DECODE_BITS-1:0] wr_addr_q;
	logic [31:0] hrdata_q;
	logic hreadyout_q;
	logic hresp_q;
	logic addr_phase;
	logic [ADDR_DECODE_BITS-1:0] addr_low;
	logic [7:0] read_byte;
	logic [7:0] wdata_byte;

	// undervoltage path
	logic uv_meta_q;
	logic uv_sync_q;
	logic uv_event;
	logic uv_clear;
	logic irq_q;

	// outputs to the analog side
	reference_out_t reference_q;
	logic [7:0] undervoltage_level_out_q;
	logic [3:0] high_delay_cycles;
	logic [3:0] low_delay_cycles;
	logic high_gate;
	logic low_gate;
	logic fast_off;

	// =========================================================
	// AHB-Lite address phase decode
	assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
	assign addr_low = haddr[ADDR_DECODE_BITS-1:0];
	assign wdata_byte = hwdata[7:0];

	// read mux; unmapped addresses read zero
	always_comb begin
		case (addr_low)
			DEAD_TIME_OFFSET: read_byte = dead_time_q;
			COARSE_OFFSET: read_byte = coarse_setpoint_q;
			FINE_OFFSET: read_byte = fine_setpoint_q & FINE_WRITE_MASK;
			UV_LEVEL_OFFSET: read_byte = undervoltage_level_q;
			PERIPH_EN_OFFSET: read_byte = analog_peripheral_enables_q;
			IRQ_STATUS_OFFSET: read_byte = irq_status_q;
			IRQ_MASK_OFFSET: read_byte = irq_mask_q;
			default: read_byte = 8'h00;
		endcase
	end

	// capture a write in the address phase, commit it in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending_q <= 1'b0;
			wr_addr_q <= '0;
		end else if (hready) begin
			wr_pending_q <= addr_phase && hwrite;
			wr_addr_q <= addr_low;
		end
	end

	// read data registered so it stands through the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata_q <= {24'h00_0000, read_byte};
		end
	end

	// zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= HRESP_OKAY;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= HRESP_OKAY;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;

	// =========================================================
	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dead_time_q <= DEAD_TIME_RESET;
		end else if (wr_pending_q && wr_addr_q == DEAD_TIME_OFFSET) begin
			dead_time_q <= wdata_byte;
		end
	end

	// coarse code is taken as written; its scaling is software's job
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coarse_setpoint_q <= COARSE_RESET;
		end else if (wr_pending_q && wr_addr_q == COARSE_OFFSET) begin
			coarse_setpoint_q <= wdata_byte;
		end
	end

	// unimplemented bits 6:5 never store anything
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fine_setpoint_q <= FINE_RESET;
		end else if (wr_pending_q && wr_addr_q == FINE_OFFSET) begin
			fine_setpoint_q <= wdata_byte & FINE_WRITE_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			undervoltage_level_q <= UV_LEVEL_RESET;
		end else if (wr_pending_q && wr_addr_q == UV_LEVEL_OFFSET) begin
			undervoltage_level_q <= wdata_byte;
		end
	end

	// bypass and fast shutoff enables; other bits are out of scope here
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_peripheral_enables_q <= PERIPH_EN_RESET;
		end else if (wr_pending_q && wr_addr_q == PERIPH_EN_OFFSET) begin
			analog_peripheral_enables_q <= wdata_byte & PERIPH_WRITE_MASK;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_mask_q <= 8'h00;
		end else if (wr_pending_q && wr_addr_q == IRQ_MASK_OFFSET) begin
			irq_mask_q <= wdata_byte & 8'h01;
		end
	end

	// =========================================================
	// undervoltage detect
	// two-stage synchroniser, the comparator toggles freely near threshold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			uv_meta_q <= 1'b0;
			uv_sync_q <= 1'b0;
		end else begin
			uv_meta_q <= undervoltage_compare_raw;
			uv_sync_q <= uv_meta_q;
		end
	end

	assign uv_event = uv_sync_q;
	assign uv_clear = wr_pending_q && wr_addr_q == IRQ_STATUS_OFFSET && wdata_byte[UV_EVENT_BIT];

	// sticky flag: set wins over a same-cycle write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status_q <= 8'h00;
		end else if (uv_event) begin
			irq_status_q[UV_EVENT_BIT] <= 1'b1;
		end else if (uv_clear) begin
			irq_status_q[UV_EVENT_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	assign irq = irq_q;

	// =========================================================
	// reference converter codes
	// with the enable clear the converter sees zero codes, so a stale set point never leaks
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			reference_q <= '0;
		end else begin
			reference_q.enable <= fine_setpoint_q.reference_converter_enable;
			reference_q.coarse_setpoint_code <= fine_setpoint_q.reference_converter_enable
				? coarse_setpoint_q : 8'h00;
			reference_q.fine_setpoint_code <= fine_setpoint_q.reference_converter_enable
				? fine_setpoint_q.fine_setpoint_code : 5'h00;
		end
	end

	assign reference_converter_enable = reference_q.enable;
	assign coarse_setpoint_code = reference_q.coarse_setpoint_code;
	assign fine_setpoint_code = reference_q.fine_setpoint_code;

	// threshold code to the analog comparator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			undervoltage_level_out_q <= UV_LEVEL_RESET;
		end else begin
			undervoltage_level_out_q <= undervoltage_level_q;
		end
	end

	assign undervoltage_level_code = undervoltage_level_out_q;

	// =========================================================
	// dead-time: delay in ns rounded up to whole clock cycles
	function automatic logic [3:0] delay_to_cycles(input logic [3:0] code, input int base_ns);
		int ns;
		ns = base_ns + int'(code) * DELAY_STEP_NS;
		return 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction

	assign high_delay_cycles = delay_to_cycles(dead_time_q.high_side_delay_code, HIGH_BASE_NS);
	assign low_delay_cycles = delay_to_cycles(dead_time_q.low_side_delay_code, LOW_BASE_NS);

	// fast shutoff acts on the synchronised level, not the sticky flag
	assign fast_off = analog_peripheral_enables_q[UV_FAST_OFF_BIT] && uv_sync_q;

	gate_turn_on_delay u_high_delay (
		.hclk(hclk),
		.hresetn(hresetn),
		.request(high_side_request),
		.bypass(analog_peripheral_enables_q[HIGH_BYPASS_BIT]),
		.kill(fast_off),
		.delay_cycles(high_delay_cycles),
		.gate_q(high_gate)
	);

	gate_turn_on_delay u_low_delay (
		.hclk(hclk),
		.hresetn(hresetn),
		.request(low_side_request),
		.bypass(analog_peripheral_enables_q[LOW_BYPASS_BIT]),
		.kill(fast_off),
		.delay_cycles(low_delay_cycles),
		.gate_q(low_gate)
	);

	assign high_side_gate_signal = high_gate;
	assign low_side_gate_signal = low_gate;

endmodule

// ==== gate_turn_on_delay.sv ====
// Purpose: delays the rising edge of one gate drive request by a programmed count
// Assumes: request is synchronous to hclk
// Notes: the falling edge passes with one cycle of latency only
`timescale 1ns/10ps
module gate_turn_on_delay
	import buck_cfg_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic request,
	input wire logic bypass,
	input wire logic kill,
	input wire logic [3:0] delay_cycles,
	output logic gate_q
);

	gate_state_t state_q;
	logic [3:0] count_q;

	// =========================================================
	// turn-on edge sequencing
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= GATE_OFF;
			count_q <= 4'h0;
		end else begin
			case (state_q)
				GATE_OFF: begin
					if (request && !kill) begin
						// bypass set skips the programmed delay
						if (bypass || delay_cycles <= 4'h1) begin
							state_q <= GATE_ON;
						end else begin
							state_q <= GATE_WAIT;
							count_q <= delay_cycles - 4'h2;
						end
					end
				end
				GATE_WAIT: begin
					if (!request || kill) begin
						state_q <= GATE_OFF;
					end else if (count_q == 4'h0) begin
						state_q <= GATE_ON;
					end else begin
						count_q <= count_q - 4'h1;
					end
				end
				GATE_ON: begin
					if (!request || kill) begin
						state_q <= GATE_OFF;
					end
				end
				default: begin
					state_q <= GATE_OFF;
				end
			endcase
		end
	end

	// gate register follows state; kill forces low at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gate_q <= 1'b0;
		end else begin
			gate_q <= (state_q == GATE_ON) && request && !kill;
		end
	end

endmodule

// ==== tb_buck_driver_setpoint_config.sv ====
// Purpose: self-checking bench for the set-point and dead-time register block
// Assumes: zero-wait bus slave, hready looped back from hreadyout
// Notes: gate latencies counted in edges after the request is driven
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb_buck_driver_setpoint_config
	import buck_cfg_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hsreq = 1'b0;
	logic lsreq = 1'b0;
	logic uv_raw = 1'b0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout, hresp, hs_gate, ls_gate, ref_en, irq;
	logic [7:0] coarse, uv_lvl;
	logic [4:0] fine;
	logic [31:0] q;
	int n;
	int n_fail = 0;
	int num_checks = 0;

	// =========================================================
	// clock and design
	always #12.5 hclk = ~hclk;
	assign hready = hreadyout;
	buck_driver_setpoint_config DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .high_side_request(hsreq), .low_side_request(lsreq),
		.undervoltage_compare_raw(uv_raw), .high_side_gate_signal(hs_gate), .low_side_gate_signal(ls_gate),
		.reference_converter_enable(ref_en), .coarse_setpoint_code(coarse), .fine_setpoint_code(fine),
		.undervoltage_level_code(uv_lvl), .irq(irq));

	// =========================================================
	// shared tasks
	task close_out;
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// bounded wait for hready at a rising edge
	task rdy;
		int i;
		i = 0;
		do begin @(posedge hclk); i++; end while (hreadyout !== 1'b1 && i < 50);
		if (i >= 50) begin n_fail++; close_out; end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= HTRANS_NONSEQ;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		q = hrdata;
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		`CHK("hrdata", e, q)
		`CHK("hresp", HRESP_OKAY, hresp)
	endtask
	// edges from request to gate high: two when a one-cycle delay folds into the flop, else cycles plus one
	function int dly(input int ns);
		int d;
		d = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (d <= 1) ? 2 : d + 1;
	endfunction
	task rise(input logic hs);
		@(posedge hclk);
		if (hs) hsreq <= 1'b1; else lsreq <= 1'b1;
		n = 0;
		do begin @(posedge hclk); #1; n++; end while ((hs ? hs_gate : ls_gate) !== 1'b1 && n < 10);
		@(posedge hclk);
		hsreq <= 1'b0;
		lsreq <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	// a single cycle below threshold must be enough
	task pulse;
		@(posedge hclk);
		uv_raw <= 1'b1;
		@(posedge hclk);
		uv_raw <= 1'b0;
		repeat (6) @(posedge hclk);
	endtask

	// =========================================================
	// scenarios
	task t_reset;
		for (int a = 0; a < 32; a += 4) rdchk(a[7:0], 32'h0);
		xfer(1'b1, 8'h1c, 32'hff);
		rdchk(8'h1c, 32'h0);
	endtask
	task t_ref;
		xfer(1'b1, COARSE_OFFSET, 32'h5a);
		xfer(1'b1, FINE_OFFSET, 32'hff);
		rdchk(FINE_OFFSET, 32'h9f);
		rdchk(COARSE_OFFSET, 32'h5a);
		`CHK("enable", 1'b1, ref_en)
		`CHK("coarse", 8'h5a, coarse)
		`CHK("fine", 5'h1f, fine)
		xfer(1'b1, FINE_OFFSET, 32'h03);
		repeat (2) @(posedge hclk);
		`CHK("coarse off", 8'h00, coarse)
		`CHK("enable off", 1'b0, ref_en)
		rdchk(FINE_OFFSET, 32'h03);
	endtask
	task t_dead;
		int cs[4];
		cs = '{0, 3, 12, 15};
		xfer(1'b1, PERIPH_EN_OFFSET, 32'h0);
		foreach (cs[i]) begin
			xfer(1'b1, DEAD_TIME_OFFSET, {24'h0, cs[i][3:0], cs[i][3:0]});
			rdchk(DEAD_TIME_OFFSET, {24'h0, cs[i][3:0], cs[i][3:0]});
			rise(1'b1);
			`CHK("high delay", dly(11 + 4 * cs[i]), n)
			rise(1'b0);
			`CHK("low delay", dly(4 + 4 * cs[i]), n)
		end
		xfer(1'b1, PERIPH_EN_OFFSET, 32'h30);
		rise(1'b1);
		`CHK("high bypass", 2, n)
		rise(1'b0);
		`CHK("low bypass", 2, n)
	endtask
	task t_uv;
		xfer(1'b1, UV_LEVEL_OFFSET, 32'h21);
		repeat (2) @(posedge hclk);
		`CHK("uv level", 8'h21, uv_lvl)
		xfer(1'b1, IRQ_MASK_OFFSET, 32'h1);
		pulse;
		`CHK("irq set", 1'b1, irq)
		rdchk(IRQ_STATUS_OFFSET, 32'h1);
		`CHK("irq held", 1'b1, irq)
		xfer(1'b1, IRQ_STATUS_OFFSET, 32'h1);
		repeat (3) @(posedge hclk);
		`CHK("irq cleared", 1'b0, irq)
		xfer(1'b1, IRQ_MASK_OFFSET, 32'h0);
		pulse;
		`CHK("irq masked", 1'b0, irq)
		rdchk(IRQ_STATUS_OFFSET, 32'h1);
		xfer(1'b1, IRQ_STATUS_OFFSET, 32'h1);
		rdchk(IRQ_STATUS_OFFSET, 32'h0);
	endtask
	// fast shutoff: both gates forced low while below threshold
	task t_fast;
		xfer(1'b1, PERIPH_EN_OFFSET, 32'h02);
		@(posedge hclk);
		hsreq <= 1'b1;
		lsreq <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK("gates on", 2'h3, {hs_gate, ls_gate})
		uv_raw <= 1'b1;
		repeat (5) @(posedge hclk);
		`CHK("gates off", 2'h0, {hs_gate, ls_gate})
		uv_raw <= 1'b0;
		hsreq <= 1'b0;
		lsreq <= 1'b0;
		xfer(1'b1, IRQ_STATUS_OFFSET, 32'h1);
	endtask

	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_ref;
		t_dead;
		t_uv;
		t_fast;
		close_out;
	end
endmodule

bind buck_driver_setpoint_config buck_cfg_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
	.high_side_request(high_side_request), .low_side_request(low_side_request),
	.undervoltage_compare_raw(undervoltage_compare_raw), .high_side_gate_signal(high_side_gate_signal),
	.low_side_gate_signal(low_side_gate_signal), .reference_converter_enable(reference_converter_enable),
	.coarse_setpoint_code(coarse_setpoint_code), .fine_setpoint_code(fine_setpoint_code),
	.undervoltage_level_code(undervoltage_level_code), .irq(irq));
